//--- design/cks_clock_ctrl.sv
// Clock source decode, reset time-out and start-up sequencing, and domain clock gating.
// Assumes oscillator and watchdog cycles arrive as synchronous one-cycle ticks and that
// domain clock enables are used by downstream gating cells.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
// How it works
// - Decode four-bit source field into clock types
// - Fuse bit reads one unprogrammed, zero programmed
// - Default fuses: calibrated RC, divide by eight
// - Extra time-out after other resets release
// - Time-out is 0, 4K or 8K watchdog cycles
// - Oscillator cycle counter holds reset until done
// - Start-up count from 6 to 32K cycles
// - Reset uses both delays; power-down or power-save wake only start-up, other wakes neither
// - Zero time-out relies on brown-out detector
// - Sleep halts unused clocks, CPU clock in every mode
// - I/O clock halted outside idle; async detection takes over
// - Flash clock gated together with CPU clock
// - Async timer clock keeps running in sleep
// - Converter clock stays on during noise reduction
// - One generator derives every domain clock but the async timer clock
// - Programmed divide fuse divides clock by eight
module cks_clock_ctrl #(
   parameter int P_TOUT_4K   = 4096,
   parameter int P_TOUT_8K   = 8192,
   parameter int P_SU_16K    = 16384,
   parameter int P_SU_32K    = 32768
) (
   // Clock and reset
   input  wire logic                         i_core_clk,
   input  wire logic                         i_rst_n,
   // Reset sources, fuses and wake-up
   input  wire logic                         i_rst_src_n,
   input  wire logic [7:0]                   i_fuse,
   input  wire logic                         i_bod_en,
   input  wire logic                         i_wake,
   // Oscillator and watchdog ticks
   input  wire logic                         i_osc_tick,
   input  wire logic                         i_wdt_tick,
   // Avalon-MM slave
   input  wire logic [cks_pkg::CKS_AW-1:0]   i_avs_address,
   input  wire logic                         i_avs_read,
   input  wire logic                         i_avs_write,
   input  wire logic [cks_pkg::CKS_DW-1:0]   i_avs_writedata,
   input  wire logic [3:0]                   i_avs_byteenable,
   output logic [cks_pkg::CKS_DW-1:0]        o_avs_readdata,
   output logic                              o_avs_waitrequest,
   // Domain clock enables and internal reset
   output logic                              o_cpu_clk_en,
   output logic                              o_flash_clk_en,
   output logic                              o_io_clk_en,
   output logic                              o_asy_clk_en,
   output logic                              o_adc_clk_en,
   output logic                              o_async_detect_en,
   output logic                              o_int_rst_n
);
   import cks_pkg::*;

   cks_state_t  state_ff;
   cks_sleep_t  mode_ff;
   logic [7:0]  fuse_ff;
   logic        asy_ena_ff;
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic        cpu_en_ff, flash_en_ff, io_en_ff, asy_en_ff, adc_en_ff, adet_ff, irst_ff;
   logic        tout_done, su_done, sys_tick, div_on, deep_sleep;
   logic        bus_req, bus_done, wr_ctrl, sleep_go, warn;
   logic [15:0] tout_target, su_target;
   cks_src_t    src;
   logic [3:0]  cksel;
   logic [1:0]  startup_time_select;

   // Source type from the selection field
   function automatic cks_src_t decode_src(input logic [3:0] sel);
      if (sel >= CKS_SEL_LP_MIN)      decode_src = CKS_SRC_LP_XTAL;
      else if (sel >= CKS_SEL_FS_MIN) decode_src = CKS_SRC_FS_XTAL;
      else if (sel >= CKS_SEL_LF_MIN) decode_src = CKS_SRC_LF_XTAL;
      else if (sel == CKS_SEL_RC128)  decode_src = CKS_SRC_RC128;
      else if (sel == CKS_SEL_RCCAL)  decode_src = CKS_SRC_RC_CAL;
      else if (sel == CKS_SEL_EXT)    decode_src = CKS_SRC_EXT;
      else                            decode_src = CKS_SRC_RSVD;
   endfunction : decode_src

   function automatic logic is_xtal(input cks_src_t s);
      is_xtal = (s == CKS_SRC_LP_XTAL) || (s == CKS_SRC_FS_XTAL);
   endfunction : is_xtal

   // Watchdog cycles of reset time-out
   function automatic logic [15:0] tout_sel(input cks_src_t s, input logic c0, input logic [1:0] su);
      logic [2:0] idx;
      idx = {c0, su};
      tout_sel = CKS_CNT_ZERO;
      if (is_xtal(s)) begin
         case (idx)
            3'h0, 3'h3, 3'h6: tout_sel = 16'(P_TOUT_4K);
            3'h1, 3'h4, 3'h7: tout_sel = 16'(P_TOUT_8K);
            default:          tout_sel = CKS_CNT_ZERO;
         endcase
      end else begin
         case (su)
            2'h0:    tout_sel = CKS_CNT_ZERO;
            2'h1:    tout_sel = 16'(P_TOUT_4K);
            default: tout_sel = 16'(P_TOUT_8K);
         endcase
      end
   endfunction : tout_sel

   // Oscillator cycles before the clock counts as stable
   function automatic logic [15:0] su_sel(input cks_src_t s, input logic c0, input logic [1:0] su);
      logic [2:0] idx;
      idx = {c0, su};
      su_sel = CKS_SU_EXT;
      if (is_xtal(s)) begin
         case (idx)
            3'h0, 3'h1:       su_sel = CKS_SU_258;
            3'h2, 3'h3, 3'h4: su_sel = CKS_SU_1K;
            default:          su_sel = 16'(P_SU_16K);
         endcase
      end else if (s == CKS_SRC_LF_XTAL) begin
         su_sel = 16'(P_SU_32K);
      end else begin
         su_sel = CKS_SU_EXT;
      end
   endfunction : su_sel

   // Fuse polarity: a field value is taken as read, zero meaning programmed
   assign cksel       = fuse_ff[CKS_FUSE_SUT_LSB-1:0];
   assign startup_time_select         = fuse_ff[CKS_FUSE_SUT_LSB+1:CKS_FUSE_SUT_LSB];
   assign div_on      = (fuse_ff[CKS_FUSE_DIV8_BIT] == CKS_FUSE_PROGRAMMED);
   assign src         = decode_src(cksel);
   assign tout_target = tout_sel(src, cksel[0], startup_time_select);
   assign su_target   = su_sel(src, cksel[0], startup_time_select);
   assign deep_sleep  = (mode_ff == CKS_SLP_PDOWN) || (mode_ff == CKS_SLP_PSAVE);
   // Zero time-out without a detector leaves supply rise unguarded
   assign warn        = (tout_target == CKS_CNT_ZERO) && !i_bod_en;

   // Fuses follow the pins only while held in reset, so targets never move mid-count
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fuse_ff <= CKS_FUSE_DEFAULT;
      end else if (state_ff == CKS_ST_HOLD) begin
         fuse_ff <= i_fuse;
      end
   end

   cks_tick_counter #(.W(16)) u_tout (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_clear    (state_ff != CKS_ST_TOUT),
      .i_tick     (i_wdt_tick),
      .i_target   (tout_target),
      .o_done     (tout_done)
   );

   cks_tick_counter #(.W(16)) u_startup (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_clear    (state_ff != CKS_ST_SUTC),
      .i_tick     (i_osc_tick),
      .i_target   (su_target),
      .o_done     (su_done)
   );

   cks_div8 u_div (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_divide   (div_on),
      .o_tick     (sys_tick)
   );

   // Bus decode
   assign bus_req  = i_avs_read || i_avs_write;
   assign bus_done = bus_req && !wait_ff;
   assign wr_ctrl  = i_avs_write && !wait_ff && (i_avs_address == CKS_ADDR_CTRL);
   assign sleep_go = wr_ctrl && i_avs_byteenable[0] && i_avs_writedata[CKS_CTRL_SLEEP_BIT];

   // Start-up sequencer
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= CKS_ST_HOLD;
      end else if (!i_rst_src_n) begin
         state_ff <= CKS_ST_HOLD;
      end else begin
         case (state_ff)
            CKS_ST_HOLD:  state_ff <= CKS_ST_TOUT;
            CKS_ST_TOUT:  if (tout_done) state_ff <= CKS_ST_SUTC;
            CKS_ST_SUTC:  if (su_done) state_ff <= CKS_ST_RUN;
            CKS_ST_RUN:   if (sleep_go) state_ff <= CKS_ST_SLEEP;
            CKS_ST_SLEEP: if (i_wake) state_ff <= deep_sleep ? CKS_ST_SUTC : CKS_ST_RUN;
            default:      state_ff <= CKS_ST_HOLD;
         endcase
      end
   end

   // Control register
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_ff    <= CKS_SLP_IDLE;
         asy_ena_ff <= 1'b0;
      end else if (wr_ctrl) begin
         if (i_avs_byteenable[0]) begin
            mode_ff <= cks_sleep_t'(i_avs_writedata[CKS_CTRL_MODE_LSB +: 3]);
         end
         if (i_avs_byteenable[1]) begin
            asy_ena_ff <= i_avs_writedata[CKS_CTRL_ASY_BIT];
         end
      end
   end

   // Domain clock enables except the async timer one come from the one divided tick
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cpu_en_ff   <= 1'b0;
         flash_en_ff <= 1'b0;
         io_en_ff    <= 1'b0;
         adc_en_ff   <= 1'b0;
         asy_en_ff   <= 1'b0;
         adet_ff     <= 1'b0;
         irst_ff     <= 1'b0;
      end else begin
         cpu_en_ff   <= sys_tick && (state_ff == CKS_ST_RUN);
         flash_en_ff <= sys_tick && (state_ff == CKS_ST_RUN);
         io_en_ff    <= sys_tick && ((state_ff == CKS_ST_RUN)
                        || ((state_ff == CKS_ST_SLEEP) && (mode_ff == CKS_SLP_IDLE)));
         adc_en_ff   <= sys_tick && ((state_ff == CKS_ST_RUN)
                        || ((state_ff == CKS_ST_SLEEP)
                            && ((mode_ff == CKS_SLP_IDLE) || (mode_ff == CKS_SLP_ADC))));
         // Own crystal or pin, so it ignores the divider and the sleep mode
         asy_en_ff   <= asy_ena_ff && (state_ff != CKS_ST_HOLD);
         adet_ff     <= (state_ff == CKS_ST_SLEEP) && (mode_ff != CKS_SLP_IDLE);
         // A wake-up start-up count keeps the core out of reset; only a reset start enters it low
         irst_ff     <= (state_ff == CKS_ST_RUN) || (state_ff == CKS_ST_SLEEP)
                        || ((state_ff == CKS_ST_SUTC) && irst_ff);
      end
   end

   // Slave answers one cycle after a request shows up
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= !(bus_req && wait_ff);
         if (i_avs_read && wait_ff) begin
            rdata_ff <= 32'h0000_0000;
            case (i_avs_address)
               CKS_ADDR_CTRL: begin
                  rdata_ff[CKS_CTRL_MODE_LSB +: 3] <= mode_ff;
                  rdata_ff[CKS_CTRL_ASY_BIT]       <= asy_ena_ff;
               end
               CKS_ADDR_STATUS: begin
                  rdata_ff[CKS_STAT_STATE_LSB +: 3] <= state_ff;
                  rdata_ff[CKS_STAT_RUN_BIT]        <= irst_ff;
                  rdata_ff[CKS_STAT_WARN_BIT]       <= warn;
                  rdata_ff[CKS_STAT_SLEEP_BIT]      <= (state_ff == CKS_ST_SLEEP);
                  rdata_ff[CKS_STAT_SRC_LSB +: 3]   <= src;
               end
               CKS_ADDR_FUSE:  rdata_ff[7:0] <= fuse_ff;
               CKS_ADDR_COUNT: rdata_ff <= {su_target, tout_target};
               default:        rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign o_avs_waitrequest = wait_ff;
   assign o_avs_readdata    = rdata_ff;
   assign o_cpu_clk_en      = cpu_en_ff;
   assign o_flash_clk_en    = flash_en_ff;
   assign o_io_clk_en       = io_en_ff;
   assign o_adc_clk_en      = adc_en_ff;
   assign o_asy_clk_en      = asy_en_ff;
   assign o_async_detect_en = adet_ff;
   assign o_int_rst_n       = irst_ff;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   AST_HOLD_WHILE_SRC: assert property (!i_rst_src_n |=> ##1 !o_int_rst_n)
      else $error("internal reset released while a reset source is active");
   AST_REL_AFTER_SU: assert property ($rose(o_int_rst_n) |-> $past(state_ff, 2) == CKS_ST_SUTC)
      else $error("internal reset released without start-up count");
   AST_TOUT_THEN_SU: assert property ((state_ff == CKS_ST_TOUT) && tout_done && i_rst_src_n
      |=> state_ff == CKS_ST_SUTC)
      else $error("time-out end did not start the start-up count");
   AST_WAKE_SKIPS_TOUT: assert property ((state_ff == CKS_ST_SLEEP) && i_wake && deep_sleep && i_rst_src_n
      |=> (state_ff == CKS_ST_SUTC) ##1 o_int_rst_n)
      else $error("deep wake did not go straight to start-up");
   AST_ZERO_TOUT: assert property ((state_ff == CKS_ST_TOUT) && (tout_target == CKS_CNT_ZERO) && i_rst_src_n
      |=> state_ff == CKS_ST_SUTC)
      else $error("zero time-out took more than one cycle");
   AST_CPU_OFF_SLEEP: assert property ((state_ff == CKS_ST_SLEEP) |=> !o_cpu_clk_en)
      else $error("CPU clock running in sleep");
   AST_FLASH_WITH_CPU: assert property (o_flash_clk_en == o_cpu_clk_en)
      else $error("flash clock not gated with CPU clock");
   AST_ADC_NOISE: assert property ((state_ff == CKS_ST_SLEEP) && (mode_ff == CKS_SLP_ADC) && sys_tick
      |=> o_adc_clk_en && !o_io_clk_en && o_async_detect_en)
      else $error("converter clock wrong in noise reduction");
   AST_ASY_IN_SLEEP: assert property ((state_ff == CKS_ST_SLEEP) && asy_ena_ff |=> o_asy_clk_en)
      else $error("async timer clock stopped in sleep");
   AST_DIV8: assert property (div_on && o_cpu_clk_en |=> !o_cpu_clk_en [*7])
      else $error("CPU clock enable faster than one in eight");
   AST_BUS_ONE_WAIT: assert property (bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer later than one cycle");
   AST_BUS_DONE_REARM: assert property (bus_done |=> o_avs_waitrequest)
      else $error("waitrequest not raised after completion");
endmodule : cks_clock_ctrl

//--- design/cks_pkg.sv
// Constants, register map and types for the clock source and start-up control block.
// Assumes a single 10 MHz core clock; oscillator and watchdog cycles arrive as one-cycle ticks.
package cks_pkg;
   // Avalon-MM slave geometry
   localparam int          CKS_AW              = 4;
   localparam int          CKS_DW              = 32;
   localparam logic [3:0]  CKS_ADDR_CTRL       = 4'h0;
   localparam logic [3:0]  CKS_ADDR_STATUS     = 4'h4;
   localparam logic [3:0]  CKS_ADDR_FUSE       = 4'h8;
   localparam logic [3:0]  CKS_ADDR_COUNT      = 4'hC;

   // Control register fields
   localparam int          CKS_CTRL_MODE_LSB   = 0;
   localparam int          CKS_CTRL_SLEEP_BIT  = 4;
   localparam int          CKS_CTRL_ASY_BIT    = 8;

   // Status and count register fields
   localparam int          CKS_STAT_STATE_LSB  = 0;
   localparam int          CKS_STAT_RUN_BIT    = 4;
   localparam int          CKS_STAT_WARN_BIT   = 5;
   localparam int          CKS_STAT_SLEEP_BIT  = 6;
   localparam int          CKS_STAT_SRC_LSB    = 8;
   localparam int          CKS_COUNT_SU_LSB    = 16;

   // Fuse byte layout; a programmed fuse reads 0
   localparam logic [7:0]  CKS_FUSE_DEFAULT    = 8'h62;
   localparam int          CKS_FUSE_SUT_LSB    = 4;
   localparam int          CKS_FUSE_DIV8_BIT   = 7;
   localparam logic        CKS_FUSE_PROGRAMMED = 1'b0;

   // Source selection codes
   localparam logic [3:0]  CKS_SEL_LP_MIN      = 4'h8;
   localparam logic [3:0]  CKS_SEL_FS_MIN      = 4'h6;
   localparam logic [3:0]  CKS_SEL_LF_MIN      = 4'h4;
   localparam logic [3:0]  CKS_SEL_RC128       = 4'h3;
   localparam logic [3:0]  CKS_SEL_RCCAL       = 4'h2;
   localparam logic [3:0]  CKS_SEL_RSVD        = 4'h1;
   localparam logic [3:0]  CKS_SEL_EXT         = 4'h0;

   // Short counts; the long ones are top-level parameters
   localparam logic [15:0] CKS_CNT_ZERO        = 16'h0000;
   localparam logic [15:0] CKS_SU_EXT          = 16'h0006;
   localparam logic [15:0] CKS_SU_258          = 16'h0102;
   localparam logic [15:0] CKS_SU_1K           = 16'h0400;
   localparam logic [2:0]  CKS_DIV8_LAST       = 3'h7;

   typedef enum logic [2:0] {
      CKS_SRC_LP_XTAL = 3'h0,
      CKS_SRC_FS_XTAL = 3'h1,
      CKS_SRC_LF_XTAL = 3'h2,
      CKS_SRC_RC128   = 3'h3,
      CKS_SRC_RC_CAL  = 3'h4,
      CKS_SRC_EXT     = 3'h5,
      CKS_SRC_RSVD    = 3'h6
   } cks_src_t;

   typedef enum logic [2:0] {
      CKS_SLP_IDLE   = 3'h0,
      CKS_SLP_ADC    = 3'h1,
      CKS_SLP_PDOWN  = 3'h2,
      CKS_SLP_PSAVE  = 3'h3,
      CKS_SLP_STBY   = 3'h6,
      CKS_SLP_XSTBY  = 3'h7
   } cks_sleep_t;

   // Gray along hold -> timeout -> start-up -> run -> sleep
   typedef enum logic [2:0] {
      CKS_ST_HOLD  = 3'b000,
      CKS_ST_TOUT  = 3'b001,
      CKS_ST_SUTC  = 3'b011,
      CKS_ST_RUN   = 3'b010,
      CKS_ST_SLEEP = 3'b110
   } cks_state_t;
endpackage : cks_pkg

//--- design/cks_tick_counter.sv
// Counts incoming ticks up to a target and flags when the target is reached.
// Assumes ticks are one-cycle pulses synchronous to the core clock.
`timescale 1ns/1ps
module cks_tick_counter #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   // Count control
   input  wire logic         i_clear,
   input  wire logic         i_tick,
   input  wire logic [W-1:0] i_target,
   output logic              o_done
);
   logic [W-1:0] cnt_ff;

   // Holds at target so a late tick cannot wrap past it
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= '0;
      end else if (i_clear) begin
         cnt_ff <= '0;
      end else if (i_tick && (cnt_ff != i_target)) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign o_done = (cnt_ff == i_target);
endmodule : cks_tick_counter

//--- design/cks_div8.sv
// System clock enable generator with optional divide by eight.
// Assumes the divide request is a static fuse level.
`timescale 1ns/1ps
module cks_div8 (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // Divide request and enable out
   input  wire logic i_divide,
   output logic      o_tick
);
   import cks_pkg::*;
   logic [2:0] div_ff;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_ff <= 3'h0;
      end else begin
         div_ff <= div_ff + 3'h1;
      end
   end

   assign o_tick = i_divide ? (div_ff == CKS_DIV8_LAST) : 1'b1;
endmodule : cks_div8

//--- testbench/cks_osc_model.sv
// Stand-in for the selected oscillator and the watchdog oscillator.
// Assumes the device counts one-cycle ticks synchronous to the core clock.
`timescale 1ns/1ps
module cks_osc_model (
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   // Run control and tick spacing, 1 = prompt, larger = slow
   input  wire logic       i_osc_run,
   input  wire logic       i_wdt_run,
   input  wire logic [3:0] i_osc_period,
   input  wire logic [3:0] i_wdt_period,
   // Tick outputs
   output logic            o_osc_tick,
   output logic            o_wdt_tick
);
   logic [3:0] osc_cnt_ff;
   logic [3:0] wdt_cnt_ff;

   // A stopped oscillator gives no ticks at all
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         osc_cnt_ff <= 4'h0;
         o_osc_tick <= 1'b0;
      end else begin
         o_osc_tick <= i_osc_run && (osc_cnt_ff + 4'h1 >= i_osc_period);
         osc_cnt_ff <= (osc_cnt_ff + 4'h1 >= i_osc_period) ? 4'h0 : osc_cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wdt_cnt_ff <= 4'h0;
         o_wdt_tick <= 1'b0;
      end else begin
         o_wdt_tick <= i_wdt_run && (wdt_cnt_ff + 4'h1 >= i_wdt_period);
         wdt_cnt_ff <= (wdt_cnt_ff + 4'h1 >= i_wdt_period) ? 4'h0 : wdt_cnt_ff + 4'h1;
      end
   end
endmodule : cks_osc_model

//--- testbench/tb_cks_clock_ctrl.sv
// Self-checking bench for the clock source and start-up control block.
// Assumes the shortened count parameters below and a one-cycle bus answer.
`timescale 1ns/1ps
module tb_cks_clock_ctrl;
   import cks_pkg::*;
   localparam int T4 = 16, T8 = 32, S16 = 40, S32 = 48;
   logic i_core_clk, i_rst_n, i_rst_src_n, i_bod_en, i_wake, i_avs_read, i_avs_write;
   logic [7:0] i_fuse;
   logic [3:0] i_avs_address, i_avs_byteenable, osc_per, wdt_per;
   logic [31:0] i_avs_writedata, o_avs_readdata, rd, prev;
   logic o_avs_waitrequest, o_cpu_clk_en, o_flash_clk_en, o_io_clk_en, o_asy_clk_en;
   logic o_adc_clk_en, o_async_detect_en, o_int_rst_n, osc_tick, wdt_tick, osc_run, wdt_run;
   logic [15:0] e_tout, e_su;
   logic [2:0] e_src, mode;
   logic [7:0] f;
   int n_mismatch, n_compared, nw, no, nc, nf, ni, na, k;
   int modes[6] = '{0, 1, 2, 3, 6, 7};

   cks_clock_ctrl #(.P_TOUT_4K(T4), .P_TOUT_8K(T8), .P_SU_16K(S16), .P_SU_32K(S32)) cks_clock_ctrl_i (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rst_src_n(i_rst_src_n), .i_fuse(i_fuse),
      .i_bod_en(i_bod_en), .i_wake(i_wake), .i_osc_tick(osc_tick), .i_wdt_tick(wdt_tick),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .o_cpu_clk_en(o_cpu_clk_en), .o_flash_clk_en(o_flash_clk_en), .o_io_clk_en(o_io_clk_en),
      .o_asy_clk_en(o_asy_clk_en), .o_adc_clk_en(o_adc_clk_en),
      .o_async_detect_en(o_async_detect_en), .o_int_rst_n(o_int_rst_n));

   cks_osc_model cks_osc_model_i (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_osc_run(osc_run), .i_wdt_run(wdt_run),
      .i_osc_period(osc_per), .i_wdt_period(wdt_per), .o_osc_tick(osc_tick), .o_wdt_tick(wdt_tick));

   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end

   task automatic results;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic hang(input string what);
      n_mismatch++;
      $display("unexpected at %0t: no answer in %s", $time, what);
      results();
   endtask : hang

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int j;
      @(posedge i_core_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      for (j = 0; j < 50; j++) begin
         @(posedge i_core_clk);
         if (o_avs_waitrequest === 1'b0) break;
      end
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      if (j >= 50) hang("bus");
   endtask : bus

   // Expected source type and counts for a fuse byte
   function automatic void expect_cfg(input logic [7:0] fz, output logic [15:0] t, output logic [15:0] s,
                                      output logic [2:0] src);
      logic [3:0] c;
      int idx;
      c = fz[3:0];
      idx = {c[0], fz[5:4]};
      src = (c >= 8) ? 3'h0 : (c >= 6) ? 3'h1 : (c >= 4) ? 3'h2 : (c == 3) ? 3'h3 : (c == 2) ? 3'h4 :
            (c == 0) ? 3'h5 : 3'h6;
      if (c >= 6) begin
         t = (idx % 3 == 0) ? 16'(T4) : (idx % 3 == 1) ? 16'(T8) : 16'h0000;
         s = (idx <= 1) ? 16'h0102 : (idx <= 4) ? 16'h0400 : 16'(S16);
      end else begin
         t = (fz[5:4] == 2'h0) ? 16'h0000 : (fz[5:4] == 2'h1) ? 16'(T4) : 16'(T8);
         s = (c == 4 || c == 5) ? 16'(S32) : 16'h0006;
      end
   endfunction : expect_cfg

   // Other reset sources stay low for hold cycles after the main reset lets go
   task automatic start(input logic [7:0] fz, input int hold);
      i_rst_n <= 1'b0;
      i_rst_src_n <= 1'b0;
      i_fuse <= fz;
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      repeat (hold) @(posedge i_core_clk);
      check(o_int_rst_n, 0, "reset held by other source");
      i_rst_src_n <= 1'b1;
      nw = 0;
      no = 0;
      for (k = 0; k < 4000 && o_int_rst_n !== 1'b1; k++) begin
         @(posedge i_core_clk);
         nw += wdt_tick;
         no += osc_tick;
      end
      if (k >= 4000) hang("start-up");
   endtask : start

   task automatic count_en(input int cyc);
      nc = 0; nf = 0; ni = 0; na = 0;
      repeat (cyc) begin
         @(posedge i_core_clk);
         nc += o_cpu_clk_en;
         nf += (o_flash_clk_en === o_cpu_clk_en);
         ni += o_io_clk_en;
         na += o_adc_clk_en;
      end
   endtask : count_en

   initial begin
      {i_rst_n, i_rst_src_n, i_bod_en, i_wake, i_avs_read, i_avs_write} = 6'h00;
      {i_fuse, i_avs_address, i_avs_writedata} = 44'h0;
      i_avs_byteenable = 4'hF;
      {osc_run, wdt_run, osc_per, wdt_per} = 10'h311;
      n_mismatch = 0;
      n_compared = 0;
      void'($urandom(32'h97AAA28F));
      start(8'h62, 6);
      check(nw >= T8, 1, "default time-out ticks");
      bus(1'b0, CKS_ADDR_FUSE, 32'h0, rd);
      check(rd, 32'h62, "default fuse");
      bus(1'b0, CKS_ADDR_COUNT, 32'h0, rd);
      check(rd, {16'h0006, 16'(T8)}, "default counts");
      $display("default start-up test done");
      for (int c = 0; c < 16; c++) begin
         f = {4'($urandom_range(0, 15)), 4'(c)};
         i_bod_en <= 1'($urandom);
         osc_per <= 4'($urandom_range(1, 3));
         wdt_per <= 4'($urandom_range(1, 3));
         expect_cfg(f, e_tout, e_su, e_src);
         start(f, 2);
         check(nw >= e_tout, 1, "time-out ticks elapsed");
         check(no >= e_su, 1, "start-up ticks elapsed");
         bus(1'b0, CKS_ADDR_COUNT, 32'h0, rd);
         check(rd, {e_su, e_tout}, "count targets");
         bus(1'b0, CKS_ADDR_STATUS, 32'h0, rd);
         check(rd[10:8], e_src, "source type");
         check(rd[5], (e_tout == 0) && !i_bod_en, "zero time-out warning");
         bus(1'b0, CKS_ADDR_FUSE, 32'h0, rd);
         check(rd[7:0], f, "fuse polarity");
         count_en(64);
         check(nc, f[7] ? 64 : 8, "cpu enable rate");
         check(nf, 64, "flash follows cpu");
         check(ni, nc, "io enable rate");
      end
      $display("source decode test done");
      bus(1'b0, 4'h2, 32'h0, rd);
      check(rd, 32'h0, "unmapped read");
      bus(1'b0, CKS_ADDR_STATUS, 32'h0, prev);
      bus(1'b1, CKS_ADDR_STATUS, 32'hFFFFFFFF, rd);
      bus(1'b0, CKS_ADDR_STATUS, 32'h0, rd);
      check(rd, prev, "read-only status");
      $display("bus test done");
      i_bod_en <= 1'b1;
      start(8'hA2, 1);
      foreach (modes[m]) begin
         mode = 3'(modes[m]);
         f[0] = 1'($urandom);
         bus(1'b1, CKS_ADDR_CTRL, {23'h0, f[0], 3'h0, 1'b1, 1'b0, mode}, rd);
         repeat (3) @(posedge i_core_clk);
         count_en(16);
         check(nc, 0, "cpu halted in sleep");
         check(nf, 16, "flash halted with cpu");
         check(ni, (mode == 0) ? 16 : 0, "io clock in sleep");
         check(o_async_detect_en, mode != 0, "async detection");
         check(na, (mode <= 1) ? 16 : 0, "converter clock in sleep");
         check(o_asy_clk_en, f[0], "async timer clock");
         bus(1'b0, CKS_ADDR_STATUS, 32'h0, rd);
         check({rd[6], rd[2:0]}, 4'hE, "sleep state");
         wdt_run <= 1'b0;
         i_wake <= 1'b1;
         @(posedge i_core_clk);
         i_wake <= 1'b0;
         for (k = 0; k < 500 && o_cpu_clk_en !== 1'b1; k++) begin
            @(posedge i_core_clk);
            check(o_int_rst_n, 1, "reset stays released on wake");
         end
         if (k >= 500) hang("wake-up");
         check(o_cpu_clk_en, 1, "woken without time-out");
         wdt_run <= 1'b1;
      end
      $display("sleep test done");
      results();
   end
endmodule : tb_cks_clock_ctrl
